// *** dws_map.svh ***
`ifndef DWS_MAP_SVH
`define DWS_MAP_SVH

// ****************************************
// timing
// ****************************************
`define DWS_CLK_NS 100
`define DWS_PORT_READY_US 10
`define DWS_PORT_READY_CYC ((`DWS_PORT_READY_US * 1000 + `DWS_CLK_NS - 1) / `DWS_CLK_NS)
`define DWS_ZC_TIMEOUT_MS 50
`define DWS_ZC_TIMEOUT_CYC ((`DWS_ZC_TIMEOUT_MS * 1000000) / `DWS_CLK_NS)
`define DWS_LINK_PERIOD_NS 800
`define DWS_SCLK_HALF_CYC (`DWS_LINK_PERIOD_NS / 2 / `DWS_CLK_NS)

// ****************************************
// shift register layout
// ****************************************
`define DWS_SHIFT_BITS 16
`define DWS_POS0_LSB 0
`define DWS_MUTE0_BIT 6
`define DWS_POS1_LSB 8
`define DWS_MUTE1_BIT 14
`define DWS_WIPER_RESET 7'h3f
`define DWS_WIPER_MUTE 7'h40
`define DWS_SHIFT_RESET 16'h3f3f

// ****************************************
// host register map
// ****************************************
`define DWS_REG_CTRL 8'h00
`define DWS_REG_TXDATA 8'h04
`define DWS_REG_STATUS 8'h08
`define DWS_REG_RXDATA 8'h0c
`define DWS_CTRL_GO_BIT 0
`define DWS_CTRL_READBACK_BIT 1
`define DWS_STATUS_BUSY_BIT 0

`endif

// *** dws_pkg.sv ***
`include "dws_map.svh"

package dws_pkg;

  typedef struct packed {
    logic [6:0] ready_cnt;
    logic ready;
    logic en_prev;
    logic clk_prev;
    logic [15:0] sreg;
    logic [3:0] bitcnt;
    logic [6:0] target0;
    logic [6:0] target1;
    logic [1:0] pend;
    logic [18:0] timer;
    logic [6:0] wiper0;
    logic [6:0] wiper1;
    logic chain;
  } dws_dev_state_t;

  typedef enum logic [2:0] {
    DWS_H_IDLE,
    DWS_H_LOW,
    DWS_H_HIGH,
    DWS_H_TAIL,
    DWS_H_GAP
  } dws_host_fsm_t;

  typedef struct packed {
    dws_host_fsm_t st;
    logic [2:0] cnt;
    logic [3:0] idx;
    logic [15:0] tx;
    logic [15:0] rx;
    logic rb;
    logic busy;
    logic en;
    logic sclk;
    logic sd;
    logic sd_oe_n;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } dws_host_state_t;

  // 6-bit position plus mute bit to a 0..64 wiper position, 64 being mute
  function automatic logic [6:0] dws_decode(input logic [7:0] ctl);
    dws_decode = ctl[`DWS_MUTE0_BIT] ? `DWS_WIPER_MUTE : {1'b0, ctl[5:0]};
  endfunction

endpackage

// *** dws_if.sv ***
`timescale 1ns/1ps
interface dws_if;
  logic xfer_en;
  logic sclk;
  logic host_sdata;
  logic host_sdata_oe_n;
  logic chain_output;
  logic sdata;

  // a released data line is pulled to the chain output by the feedback resistor
  assign sdata = host_sdata_oe_n ? chain_output : host_sdata;

  modport dev (
    input xfer_en,
    input sclk,
    input sdata,
    output chain_output
  );

  modport host (
    output xfer_en,
    output sclk,
    output host_sdata,
    output host_sdata_oe_n,
    input chain_output
  );
endinterface

// *** dws_sync.sv ***
`timescale 1ns/1ps
module dws_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // asynchronous level in, synchronised level out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } dws_sync_state_t;

  dws_sync_state_t st_q;
  dws_sync_state_t st_d;

  always_comb begin
    st_d.s1 = d;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign q = st_q.s2;
endmodule

// *** dws_device.sv ***
`timescale 1ns/1ps
// Contract
// - serial port usable ten microseconds after power-up
// - both wipers start at position 63
// - position 64 means mute, 0..63 attenuate
// - transfers start when enable rises, accepted while high
// - data sampled on each rising shift clock
// - host sends pot-0 byte before pot-1
// - 16-bit register, low byte pot 0
// - bits 0-5 position, bit 6 mutes pot 0
// - bit 7 ignored
// - bits 8-13 position, bit 14 mutes pot 1
// - bit 15 ignored
// - least significant bit travels first
// - host clocks exactly sixteen bits per device
// - enable fall loads both wipers together
// - chain output follows bit 0 promptly
// - chained devices need sixteen bits each
// - read-back: host leaves data line undriven
// - bit 0 shown at chain output before clocking
// - rising edge shifts in, next bit appears
// - full circulation reloads unchanged wiper values
// - gate low: wait equal potential or 50 ms
// - gate high: apply wiper changes directly
`include "dws_map.svh"

module dws_device
  import dws_pkg::*;
#(
  parameter int ZC_TIMEOUT_CYC = `DWS_ZC_TIMEOUT_CYC
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // serial link
  dws_if.dev link,
  // analog side status
  input wire logic zero_cross_gate,
  input wire logic [1:0] terminals_equal,
  // wiper settings and status
  output logic [6:0] wiper0_pos,
  output logic [6:0] wiper1_pos,
  output logic [1:0] wiper_pending,
  output logic [15:0] shift_value,
  output logic port_ready
);

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [5:0] pins_s;
  logic en_s;
  logic sclk_s;
  logic sd_s;
  logic zcg_s;
  logic [1:0] zeq_s;

  // all link pins share one two-stage synchroniser, so data, clock and enable keep
  // their order; the price is that every edge is seen two cycles late
  dws_sync #(.W(6)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({terminals_equal, zero_cross_gate, link.sdata, link.sclk, link.xfer_en}),
    .q(pins_s)
  );

  assign en_s = pins_s[0];
  assign sclk_s = pins_s[1];
  assign sd_s = pins_s[2];
  assign zcg_s = pins_s[3];
  assign zeq_s = pins_s[5:4];

  // ****************************************
  // state
  // ****************************************
  dws_dev_state_t q;
  dws_dev_state_t d;

  logic sclk_rise;
  logic en_rise;
  logic en_fall;
  logic timed_out;

  // ****************************************
  // helpers
  // ****************************************
  // a pending wiper moves at once with the gate high, at a zero crossing, or on timeout
  function automatic logic apply_now(input logic pending, input logic gate,
    input logic equal, input logic expired);
    apply_now = pending && (gate || equal || expired);
  endfunction

  always_comb begin
    d = q;

    // ****************************************
    // edge detection
    // ****************************************
    // edges count only once the port is ready
    sclk_rise = q.ready && en_s && sclk_s && !q.clk_prev;
    en_rise = q.ready && en_s && !q.en_prev;
    en_fall = q.ready && !en_s && q.en_prev;
    timed_out = q.timer >= 19'(ZC_TIMEOUT_CYC - 1);

    // ****************************************
    // power-up hold-off
    // ****************************************
    // the port ignores the pins until the power-up count has run out;
    // a limitation: bits clocked before port_ready goes high are lost
    if (!q.ready) begin
      if (q.ready_cnt == 7'(`DWS_PORT_READY_CYC - 1)) begin
        d.ready = 1'b1;
      end else begin
        d.ready_cnt = q.ready_cnt + 7'h01;
      end
    end
    d.en_prev = en_s;
    d.clk_prev = sclk_s;

    // ****************************************
    // shift path
    // ****************************************
    // the bit count restarts with each transfer so stray edges cannot pile up
    if (en_rise) begin
      d.bitcnt = 4'h0;
    end

    // shifting only happens with enable high; otherwise edges pass unseen
    if (sclk_rise) begin
      d.sreg = {sd_s, q.sreg[15:1]};
      d.bitcnt = q.bitcnt + 4'h1;
    end

    // ****************************************
    // zero-crossing gated apply
    // ****************************************
    // one timeout serves both wipers: it runs from the enable fall, not per pot
    if (q.pend != 2'b00 && !timed_out) begin
      d.timer = q.timer + 19'h00001;
    end
    if (apply_now(q.pend[0], zcg_s, zeq_s[0], timed_out)) begin
      d.wiper0 = q.target0;
      d.pend[0] = 1'b0;
    end
    if (apply_now(q.pend[1], zcg_s, zeq_s[1], timed_out)) begin
      d.wiper1 = q.target1;
      d.pend[1] = 1'b0;
    end

    // ****************************************
    // load at enable fall
    // ****************************************
    // a load in the same cycle as an apply wins: the newest setting stands.
    // a transfer that is not a whole multiple of sixteen bits loads nothing,
    // trading strict pin behaviour for protection against stray clocks
    if (en_fall) begin
      d.bitcnt = 4'h0;
      if (q.bitcnt == 4'h0) begin
        d.target0 = dws_decode(q.sreg[`DWS_POS0_LSB +: 8]);
        d.target1 = dws_decode(q.sreg[`DWS_POS1_LSB +: 8]);
        d.pend = 2'b11;
        d.timer = '0;
      end
    end

    // ****************************************
    // chain output
    // ****************************************
    // taken from the next register value so the pin moves with the shift itself
    d.chain = d.sreg[0];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // reset shift value matches the power-up wipers: an early read-back is harmless
      q <= '{
        ready_cnt: 7'h00,
        ready: 1'b0,
        en_prev: 1'b0,
        clk_prev: 1'b0,
        sreg: `DWS_SHIFT_RESET,
        bitcnt: 4'h0,
        target0: `DWS_WIPER_RESET,
        target1: `DWS_WIPER_RESET,
        pend: 2'b00,
        timer: 19'h00000,
        wiper0: `DWS_WIPER_RESET,
        wiper1: `DWS_WIPER_RESET,
        chain: 1'b1
      };
    end else begin
      q <= d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign link.chain_output = q.chain;
  assign wiper0_pos = q.wiper0;
  assign wiper1_pos = q.wiper1;
  assign wiper_pending = q.pend;
  assign shift_value = q.sreg;
  assign port_ready = q.ready;

endmodule

// *** dws_host.sv ***
`timescale 1ns/1ps
`include "dws_map.svh"
module dws_host
  import dws_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial link
  dws_if.host link
);

  // ****************************************
  // chain output synchroniser
  // ****************************************
  logic chain_s;

  dws_sync #(.W(1)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d(link.chain_output),
    .q(chain_s)
  );

  // ****************************************
  // state
  // ****************************************
  dws_host_state_t q;
  dws_host_state_t d;

  logic setup;
  logic access;
  logic half_done;

  always_comb begin
    d = q;
    setup = psel && !penable;
    access = psel && penable && q.pready;
    half_done = q.cnt == 3'(`DWS_SCLK_HALF_CYC - 1);

    // ****************************************
    // apb: one wait-free access phase per transfer
    // ****************************************
    d.pready = setup;
    d.pslverr = 1'b0;
    if (setup) begin
      d.prdata = 32'h00000000;
      case (paddr)
        `DWS_REG_CTRL: d.prdata = {30'h0, q.rb, 1'b0};
        `DWS_REG_TXDATA: d.prdata = {16'h0000, q.tx};
        `DWS_REG_STATUS: d.prdata = {31'h0, q.busy};
        `DWS_REG_RXDATA: d.prdata = {16'h0000, q.rx};
        default: d.pslverr = 1'b1;
      endcase
    end

    d.cnt = half_done ? 3'h0 : q.cnt + 3'h1;

    // ****************************************
    // serial sequencer
    // ****************************************
    case (q.st)
      DWS_H_IDLE: begin
        d.cnt = 3'h0;
        d.sd_oe_n = 1'b0;
        if (access && pwrite && paddr == `DWS_REG_TXDATA) begin
          d.tx = pwdata[15:0];
        end
        // a go while busy cannot happen here: writes only land in idle
        if (access && pwrite && paddr == `DWS_REG_CTRL) begin
          d.rb = pwdata[`DWS_CTRL_READBACK_BIT];
          if (pwdata[`DWS_CTRL_GO_BIT]) begin
            d.st = DWS_H_LOW;
            d.busy = 1'b1;
            d.en = 1'b1;
            d.idx = 4'h0;
            d.sd = q.tx[0];
            d.sd_oe_n = pwdata[`DWS_CTRL_READBACK_BIT];
          end
        end
      end
      DWS_H_LOW: begin
        if (half_done) begin
          d.st = DWS_H_HIGH;
          d.sclk = 1'b1;
          d.rx = {chain_s, q.rx[15:1]};
        end
      end
      DWS_H_HIGH: begin
        if (half_done) begin
          d.sclk = 1'b0;
          d.idx = q.idx + 4'h1;
          d.sd = q.tx[4'(q.idx + 4'h1)];
          d.st = (q.idx == 4'hf) ? DWS_H_TAIL : DWS_H_LOW;
        end
      end
      DWS_H_TAIL: begin
        if (half_done) begin
          d.en = 1'b0;
          d.st = DWS_H_GAP;
        end
      end
      DWS_H_GAP: begin
        if (half_done) begin
          d.busy = 1'b0;
          d.sd_oe_n = 1'b0;
          d.st = DWS_H_IDLE;
        end
      end
      default: begin
        d.st = DWS_H_IDLE;
      end
    endcase

    // registers other than the sequencer stay writable only when idle
    if (q.st != DWS_H_IDLE) begin
      d.tx = q.tx;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '{
        st: DWS_H_IDLE,
        cnt: 3'h0,
        idx: 4'h0,
        tx: 16'h0000,
        rx: 16'h0000,
        rb: 1'b0,
        busy: 1'b0,
        en: 1'b0,
        sclk: 1'b0,
        sd: 1'b0,
        sd_oe_n: 1'b0,
        pready: 1'b0,
        pslverr: 1'b0,
        prdata: 32'h00000000
      };
    end else begin
      q <= d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign link.xfer_en = q.en;
  assign link.sclk = q.sclk;
  assign link.host_sdata = q.sd;
  assign link.host_sdata_oe_n = q.sd_oe_n;

endmodule

// *** dws_link_monitor.sv ***
`timescale 1ns/1ps
module dws_link_monitor (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // link wires
  input wire logic xfer_en,
  input wire logic sclk,
  input wire logic host_sdata,
  input wire logic host_sdata_oe_n,
  input wire logic chain_output,
  input wire logic sdata
);
  logic [15:0] sh_q;
  logic [4:0] n_q;
  logic sc_q;

  // shadow of the device register, fed from the resolved wire
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh_q <= 16'h3f3f;
      n_q <= 5'h0;
      sc_q <= 1'b0;
    end else begin
      sc_q <= sclk;
      if (!xfer_en) begin
        n_q <= 5'h0;
      end else if (sclk && !sc_q) begin
        n_q <= n_q + 5'h1;
        sh_q <= {sdata, sh_q[15:1]};
      end
    end
  end

  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_high;
    sclk [*4] ##1 !sclk;
  endsequence
  sequence s_low;
    !sclk [*4];
  endsequence

  a_high_phase: assert property ($rose(sclk) |-> s_high)
    else $error("shift clock high phase wrong");
  a_low_phase: assert property ($fell(sclk) |-> s_low)
    else $error("shift clock low phase wrong");
  a_start_low: assert property ($rose(xfer_en) |-> !sclk)
    else $error("enable rose with clock high");
  a_data_held: assert property (xfer_en && sclk |-> $stable(host_sdata))
    else $error("data moved while clock high");
  a_chain_shift: assert property ($rose(sclk) && xfer_en |-> ##6 chain_output == sh_q[0])
    else $error("chain output not next bit");
  a_enable_bit0: assert property ($rose(xfer_en) |-> chain_output == sh_q[0])
    else $error("bit 0 missing at enable");
  a_idle_hold: assert property (!xfer_en |=> $stable(chain_output))
    else $error("chain moved while idle");
  a_sixteen_bits: assert property ($fell(xfer_en) |-> n_q == 5'h10)
    else $error("transfer not sixteen bits");
  a_oe_steady: assert property (xfer_en && $past(xfer_en) |-> $stable(host_sdata_oe_n))
    else $error("drive enable moved in transfer");
endmodule

// *** test_dual_wiper_serial_control.sv ***
`timescale 1ns/1ps
`include "dws_map.svh"
module test_dual_wiper_serial_control;
  import dws_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, zc, pready, pslverr, er, prdy;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] teq, pend;
  logic [6:0] w0, w1;
  logic [15:0] sv;
  int err_total = 0;
  int samples_checked = 0;

  dws_if link_if();
  dws_host dws_host_inst(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(link_if));
  // short timeout keeps the run brief
  dws_device #(.ZC_TIMEOUT_CYC(50)) dws_device_inst(.pclk(pclk), .presetn(presetn),
    .link(link_if), .zero_cross_gate(zc), .terminals_equal(teq), .wiper0_pos(w0),
    .wiper1_pos(w1), .wiper_pending(pend), .shift_value(sv), .port_ready(prdy));
  dws_link_monitor dws_link_monitor_inst(.pclk(pclk), .presetn(presetn),
    .xfer_en(link_if.xfer_en), .sclk(link_if.sclk), .host_sdata(link_if.host_sdata),
    .host_sdata_oe_n(link_if.host_sdata_oe_n), .chain_output(link_if.chain_output),
    .sdata(link_if.sdata));

  // ****
  // helpers
  // ****
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task send(input logic [15:0] tx, input logic rb);
    apb(1'b1, `DWS_REG_TXDATA, {16'h0, tx});
    apb(1'b1, `DWS_REG_CTRL, {30'h0, rb, 1'b1});
    do apb(1'b0, `DWS_REG_STATUS, 32'h0); while (rd[0] !== 1'b0);
    repeat (4) @(posedge pclk);
  endtask

  task wr(input logic [15:0] tx, input logic [6:0] e0, input logic [6:0] e1);
    send(tx, 1'b0);
    chk(32'(w0), 32'(e0));
    chk(32'(w1), 32'(e1));
    chk(32'(sv), 32'(tx));
  endtask

  // ****
  // scenarios
  // ****
  task t_reset;
    chk(32'(w0), 32'h3f);
    chk(32'(w1), 32'h3f);
    repeat (90) @(posedge pclk);
    chk(32'(prdy), 32'h0);
    repeat (13) @(posedge pclk);
    chk(32'(prdy), 32'h1);
  endtask

  task t_write;
    wr(16'hd5a5, 7'h25, 7'h40);
    wr(16'h3f40, 7'h40, 7'h3f);
  endtask

  task t_readback;
    send(16'h1234, 1'b1);
    chk(32'(w0), 32'h40);
    chk(32'(w1), 32'h3f);
    apb(1'b0, `DWS_REG_RXDATA, 32'h0);
    chk(rd, 32'h3f40);
  endtask

  task t_zero;
    zc <= 1'b0;
    wr(16'h0102, 7'h40, 7'h3f);
    chk(32'(pend), 32'h3);
    repeat (50) @(posedge pclk);
    chk(32'(w0), 32'h02);
    chk(32'(w1), 32'h01);
    teq <= 2'b01;
    wr(16'h0304, 7'h04, 7'h01);
    chk(32'(pend), 32'h2);
    repeat (50) @(posedge pclk);
    chk(32'(w1), 32'h03);
    teq <= 2'b00;
    zc <= 1'b1;
  endtask

  task t_bad;
    apb(1'b0, 8'h10, 32'h0);
    chk(32'(er), 32'h1);
    chk(rd, 32'h0);
  endtask

  task conclude;
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // a hang past this span is counted as a failure
  initial begin
    #1000000;
    err_total++;
    conclude;
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    zc = 1'b1;
    teq = 2'b00;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_write;
    t_readback;
    t_zero;
    t_bad;
    conclude;
  end
endmodule
